// file: rtl/lnh_baud_gen.sv
/*
 * lnh_baud_gen: bit-time tick generator. One sample every divisor clocks,
 * one bit every 16 or 8 samples.
 * Assumes a divisor of zero means the generator is stopped.
 */
`timescale 1ns/100ps
module lnh_baud_gen
    import lnh_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [DIV_W-1:0] divisor,
    input  wire logic             over,
    input  wire logic             restart,
    output logic                  bit_tick
);

    logic [DIV_W-1:0] clk_cnt;
    logic [3:0]       smp_cnt;
    logic [DIV_W-1:0] next_clk_cnt;
    logic [3:0]       next_smp_cnt;
    logic             next_bit_tick;
    logic [3:0]       smp_last;

    always_comb begin
        smp_last      = over ? LNH_OSR8_LAST : LNH_OSR16_LAST; // R15
        next_clk_cnt  = clk_cnt;
        next_smp_cnt  = smp_cnt;
        next_bit_tick = 1'b0;
        if (restart || divisor == '0) begin
            next_clk_cnt = '0;
            next_smp_cnt = '0;
        end else if (clk_cnt >= divisor - 1'b1) begin
            next_clk_cnt = '0;
            if (smp_cnt >= smp_last) begin
                next_smp_cnt  = '0;
                next_bit_tick = 1'b1;
            end else begin
                next_smp_cnt = smp_cnt + 4'h1;
            end
        end else begin
            next_clk_cnt = clk_cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_cnt  <= '0;
            smp_cnt  <= 4'h0;
            bit_tick <= 1'b0;
        end else begin
            clk_cnt  <= next_clk_cnt;
            smp_cnt  <= next_smp_cnt;
            bit_tick <= next_bit_tick;
        end
    end

endmodule : lnh_baud_gen

// file: rtl/lnh_lin_node.sv
/*
 * lnh_lin_node: LIN node role, baud configuration and master header sender
 * behind an APB slave, with sticky interrupt status.
 * Assumes APB master timing, and a receiver outside that pulses sync_done
 * with the measured divisor when slave synchronization finishes.
 */
// Register access over APB and the register addresses were decided locally.
// Overview of operation
// R1: role field value 0xA selects LIN master, 0xB selects LIN slave.
// R2: software issues transmitter and receiver resets after every role change except the first after reset.
// R3: in master role the bit rate comes from the baud divider register.
// R4: in slave role a write to the baud divider register is copied into the bus baud capture register.
// R5: in slave role the measured divisor is written into the capture register when synchronization ends.
// R6: in master role writing the identifier starts the header at once and drops the holding-free flag; the code starts it only from idle, not during a header.
// R7: break, sync and identifier fields go out back to back with no software action.
// R8: the break field is thirteen dominant bit times and one recessive bit time.
// R9: the sync field is one ordinary character of value 0x55.
// R10: the identifier field carries the written character, with optional automatic parity bits.
// R11: the holding-free flag rises when the identifier moves into the shift register.
// R12: the break-sent flag sets when the break field is complete.
// R13: the identifier-sent flag sets when the identifier field has been sent.
// R14: writing one to the clear-status command bit clears both sent flags.
// R15: the oversampling bit picks 16 samples per bit at zero and 8 at one.
// R16: dominant is driven low, recessive high, and the line idles high.
`timescale 1ns/100ps
module lnh_lin_node
    import lnh_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sync_done,
    input  wire logic [15:0] sync_baud,
    output logic             lin_tx,
    output logic             irq
);

    // ****************************************************************
    // helpers and state
    // ****************************************************************
    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a == LNH_OFF_CTRL) || (a == LNH_OFF_MODE) || (a == LNH_OFF_STATUS) ||
                     (a == LNH_OFF_BAUD_DIV) || (a == LNH_OFF_BAUD_CAP) || (a == LNH_OFF_IDENT) ||
                     (a == LNH_OFF_IRQ_ST) || (a == LNH_OFF_IRQ_MASK);
    endfunction : reg_mapped

    // protected identifier: bits 6 and 7 replaced by parity when enabled
    function automatic logic [7:0] ident_char(input logic [7:0] id, input logic par);
        ident_char = par ? {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id[5:0]} : id;
    endfunction : ident_char
    logic [3:0]           role;
    logic                 over;
    logic                 par_en;
    logic [15:0]          baud_div;
    logic [15:0]          baud_cap;
    logic [7:0]           ident;
    logic                 tx_holding_free_flag;
    logic                 break_sent_flag;
    logic                 identifier_sent_flag;
    logic [LNH_IRQ_W-1:0] irq_st;
    logic [LNH_IRQ_W-1:0] irq_mask;
    lnh_state_t           state;
    logic [13:0]          shift;
    logic [3:0]           bits_left;
    logic [3:0]           next_role;
    logic                 next_over;
    logic                 next_par_en;
    logic [15:0]          next_baud_div;
    logic [15:0]          next_baud_cap;
    logic [7:0]           next_ident;
    logic                 next_tx_free;
    logic                 next_break_sent;
    logic                 next_ident_sent;
    logic [LNH_IRQ_W-1:0] next_irq_st;
    logic [LNH_IRQ_W-1:0] next_irq_mask;
    lnh_state_t           next_state;
    logic [13:0]          next_shift;
    logic [3:0]           next_bits_left;
    logic                 next_lin_tx;
    logic                 next_irq;
    logic [31:0]          next_prdata;
    logic                 next_pready;
    logic                 next_pslverr;
    logic                 access;
    logic                 wr;
    logic                 is_master;
    logic                 is_slave;
    logic                 hdr_go;
    logic                 bit_tick;
    logic                 field_end;
    logic                 brk_done;
    logic                 id_done;
    logic [15:0]          divisor;

    // ****************************************************************
    // bit timing and apb decode
    // ****************************************************************
    assign is_master = (role == LNH_ROLE_MASTER); // R1
    assign is_slave  = (role == LNH_ROLE_SLAVE);  // R1
    assign divisor   = is_master ? baud_div : baud_cap; // R3
    lnh_baud_gen #(.DIV_W(DIV_W)) u_baud (
        .pclk     (pclk),
        .presetn  (presetn),
        .divisor  (divisor[DIV_W-1:0]),
        .over     (over),
        .restart  (hdr_go),
        .bit_tick (bit_tick)
    );
    assign access    = psel && penable && pready;
    assign wr        = access && pwrite && reg_mapped(paddr);
    // a header already in flight is not restarted by a second write
    assign hdr_go    = wr && paddr == LNH_OFF_IDENT && is_master && state == LNH_IDLE; // R6
    assign field_end = bit_tick && bits_left == 4'h1;
    assign brk_done  = field_end && state == LNH_BREAK;
    assign id_done   = field_end && state == LNH_IDENT;
    // ****************************************************************
    // configuration registers
    // ****************************************************************
    always_comb begin
        next_role     = role;
        next_over     = over;
        next_par_en   = par_en;
        next_baud_div = baud_div;
        next_baud_cap = baud_cap;
        next_ident    = ident;
        next_irq_mask = irq_mask;
        if (wr && paddr == LNH_OFF_MODE) begin
            next_role   = pwdata[LNH_MODE_ROLE_LSB +: 4];
            next_over   = pwdata[LNH_MODE_OVER];
            next_par_en = pwdata[LNH_MODE_PAR_EN];
        end
        if (wr && paddr == LNH_OFF_BAUD_DIV) begin
            next_baud_div = pwdata[15:0];
            if (is_slave) begin
                next_baud_cap = pwdata[15:0]; // R4
            end
        end
        // a measurement landing with a divider write wins: it is newer bus evidence
        if (is_slave && sync_done) begin
            next_baud_cap = sync_baud; // R5
        end
        if (wr && paddr == LNH_OFF_IDENT) begin
            next_ident = pwdata[7:0];
        end
        if (wr && paddr == LNH_OFF_IRQ_MASK) begin
            next_irq_mask = pwdata[LNH_IRQ_W-1:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            role     <= LNH_RST_ROLE;
            over     <= 1'b0;
            par_en   <= 1'b0;
            baud_div <= LNH_RST_BAUD;
            baud_cap <= LNH_RST_BAUD;
            ident    <= 8'h00;
            irq_mask <= LNH_RST_IRQ_MASK;
        end else begin
            role     <= next_role;
            over     <= next_over;
            par_en   <= next_par_en;
            baud_div <= next_baud_div;
            baud_cap <= next_baud_cap;
            ident    <= next_ident;
            irq_mask <= next_irq_mask;
        end
    end
    // ****************************************************************
    // header sequencer
    // ****************************************************************
    always_comb begin
        next_state      = state;
        next_shift      = shift;
        next_bits_left  = bits_left;
        next_tx_free    = tx_holding_free_flag;
        next_break_sent = break_sent_flag;
        next_ident_sent = identifier_sent_flag;
        if (wr && paddr == LNH_OFF_CTRL && pwdata[LNH_CTRL_CLR_STAT]) begin
            next_break_sent = 1'b0; // R14
            next_ident_sent = 1'b0; // R14
        end
        case (state)
            LNH_IDLE: begin
                if (hdr_go) begin
                    next_state     = LNH_BREAK;
                    next_shift     = 14'h2000; // R8
                    next_bits_left = LNH_BREAK_BITS;
                    next_tx_free   = 1'b0; // R6
                end
            end
            LNH_BREAK, LNH_SYNC, LNH_IDENT: begin
                if (field_end) begin
                    case (state)
                        LNH_BREAK: begin
                            next_state      = LNH_SYNC; // R7
                            next_shift      = {4'h0, 1'b1, LNH_SYNC_CHAR, 1'b0}; // R9
                            next_bits_left  = LNH_CHAR_BITS;
                            next_break_sent = 1'b1; // R12
                        end
                        LNH_SYNC: begin
                            next_state     = LNH_IDENT; // R7
                            next_shift     = {4'h0, 1'b1, ident_char(ident, par_en), 1'b0}; // R10
                            next_bits_left = LNH_CHAR_BITS;
                            next_tx_free   = 1'b1; // R11
                        end
                        default: begin
                            next_state      = LNH_IDLE;
                            next_shift      = '0;
                            next_bits_left  = 4'h0;
                            next_ident_sent = 1'b1; // R13
                        end
                    endcase
                end else if (bit_tick) begin
                    next_shift     = {1'b0, shift[13:1]};
                    next_bits_left = bits_left - 4'h1;
                end
            end
            default: begin
                next_state = LNH_IDLE;
            end
        endcase
        // transmitter reset aborts the header and frees the holding stage
        if (wr && paddr == LNH_OFF_CTRL && pwdata[LNH_CTRL_TX_RESET]) begin
            next_state     = LNH_IDLE;
            next_shift     = '0;
            next_bits_left = 4'h0;
            next_tx_free   = 1'b1;
        end
        next_lin_tx = (next_state == LNH_IDLE) ? 1'b1 : next_shift[0]; // R16
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                <= LNH_IDLE;
            shift                <= '0;
            bits_left            <= 4'h0;
            tx_holding_free_flag <= 1'b1;
            break_sent_flag      <= 1'b0;
            identifier_sent_flag <= 1'b0;
            lin_tx               <= 1'b1;
        end else begin
            state                <= next_state;
            shift                <= next_shift;
            bits_left            <= next_bits_left;
            tx_holding_free_flag <= next_tx_free;
            break_sent_flag      <= next_break_sent;
            identifier_sent_flag <= next_ident_sent;
            lin_tx               <= next_lin_tx;
        end
    end
    // ****************************************************************
    // apb answer and interrupt
    // ****************************************************************
    always_comb begin
        next_pready  = psel && !penable;
        next_pslverr = psel && !penable && !reg_mapped(paddr);
        next_prdata  = prdata;
        if (psel && !penable) begin
            next_prdata = 32'h0000_0000;
            case (paddr)
                LNH_OFF_MODE:     next_prdata[5:0] = {par_en, over, role};
                LNH_OFF_STATUS:   next_prdata[3:0] = {state != LNH_IDLE, identifier_sent_flag,
                                                      break_sent_flag, tx_holding_free_flag};
                LNH_OFF_BAUD_DIV: next_prdata[15:0] = baud_div;
                LNH_OFF_BAUD_CAP: next_prdata[15:0] = baud_cap;
                LNH_OFF_IDENT:    next_prdata[7:0] = ident;
                LNH_OFF_IRQ_ST:   next_prdata[LNH_IRQ_W-1:0] = irq_st;
                LNH_OFF_IRQ_MASK: next_prdata[LNH_IRQ_W-1:0] = irq_mask;
                default:          next_prdata = 32'h0000_0000;
            endcase
        end
        next_irq_st = irq_st;
        // clear only what the read reported, so a later event survives
        if (access && !pwrite && paddr == LNH_OFF_IRQ_ST) begin
            next_irq_st = irq_st & ~prdata[LNH_IRQ_W-1:0];
        end
        next_irq_st = next_irq_st | {is_slave && sync_done, id_done, brk_done};
        next_irq    = |(next_irq_st & next_irq_mask);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq_st  <= '0;
            irq     <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            irq_st  <= next_irq_st;
            irq     <= next_irq;
        end
    end
    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence brk_end_s;
        state == LNH_BREAK && field_end && !(wr && paddr == LNH_OFF_CTRL && pwdata[LNH_CTRL_TX_RESET]);
    endsequence
    sequence sync_end_s;
        state == LNH_SYNC && field_end && !(wr && paddr == LNH_OFF_CTRL && pwdata[LNH_CTRL_TX_RESET]);
    endsequence
    role_gate_a: assert property (state == LNH_IDLE && role != LNH_ROLE_MASTER |=> state == LNH_IDLE) // R1
        else $error("header started outside master role");
    tx_free_fall_a: assert property (hdr_go |=> !tx_holding_free_flag && state == LNH_BREAK) // R6
        else $error("header start did not drop holding-free flag");
    break_low_a: assert property (state == LNH_BREAK && bits_left > 4'h1 |-> !lin_tx) // R8
        else $error("break bit not dominant");
    break_len_a: assert property (hdr_go |=> bits_left == 4'hE) // R8
        else $error("break length wrong");
    field_order_a: assert property (brk_end_s |=> state == LNH_SYNC ##0 shift[9:0] == 10'h2AA) // R7 R9
        else $error("sync field not after break");
    ident_free_a: assert property (sync_end_s |=> state == LNH_IDENT && tx_holding_free_flag) // R11
        else $error("identifier load did not free holding stage");
    brk_flag_a: assert property (brk_end_s |=> break_sent_flag) // R12
        else $error("break-sent flag not set");
    id_flag_a: assert property (id_done |=> identifier_sent_flag && state == LNH_IDLE) // R13
        else $error("identifier-sent flag not set");
    clr_flags_a: assert property (wr && paddr == 8'h00 && pwdata[8] && !brk_done && !id_done
                                  |=> !break_sent_flag && !identifier_sent_flag) // R14
        else $error("clear-status left a flag set");
    slave_copy_a: assert property (is_slave && wr && paddr == 8'h0C && !sync_done
                                   |=> baud_cap == $past(pwdata[15:0])) // R4
        else $error("divider not copied to capture");
    sync_update_a: assert property (is_slave && sync_done |=> baud_cap == $past(sync_baud)) // R5
        else $error("measured rate not captured");
    idle_high_a: assert property (state == LNH_IDLE |-> lin_tx) // R16
        else $error("line not recessive while idle");

endmodule : lnh_lin_node

// file: rtl/lnh_pkg.sv
/*
 * lnh_pkg: register map, field positions, reset values, node role codes and
 * header field constants shared by the LIN header control block.
 * Assumes a 32-bit APB register bus with byte addresses on 8 address bits.
 */
package lnh_pkg;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] LNH_OFF_CTRL     = 8'h00;
    localparam logic [7:0] LNH_OFF_MODE     = 8'h04;
    localparam logic [7:0] LNH_OFF_STATUS   = 8'h08;
    localparam logic [7:0] LNH_OFF_BAUD_DIV = 8'h0C;
    localparam logic [7:0] LNH_OFF_BAUD_CAP = 8'h10;
    localparam logic [7:0] LNH_OFF_IDENT    = 8'h14;
    localparam logic [7:0] LNH_OFF_IRQ_ST   = 8'h20;
    localparam logic [7:0] LNH_OFF_IRQ_MASK = 8'h24;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int LNH_CTRL_RX_RESET  = 0;
    localparam int LNH_CTRL_TX_RESET  = 1;
    localparam int LNH_CTRL_CLR_STAT  = 8;
    localparam int LNH_MODE_ROLE_LSB  = 0;
    localparam int LNH_MODE_OVER      = 4;
    localparam int LNH_MODE_PAR_EN    = 5;
    localparam int LNH_STAT_TX_FREE   = 0;
    localparam int LNH_STAT_BREAK     = 1;
    localparam int LNH_STAT_IDENT     = 2;
    localparam int LNH_STAT_BUSY      = 3;
    localparam int LNH_IRQ_BREAK      = 0;
    localparam int LNH_IRQ_IDENT      = 1;
    localparam int LNH_IRQ_SYNC       = 2;
    localparam int LNH_IRQ_W          = 3;

    // ****************************************************************
    // node roles and reset values
    // ****************************************************************
    localparam logic [3:0]  LNH_ROLE_MASTER   = 4'hA;
    localparam logic [3:0]  LNH_ROLE_SLAVE    = 4'hB;
    localparam logic [3:0]  LNH_RST_ROLE      = 4'h0;
    localparam logic [15:0] LNH_RST_BAUD      = 16'h0000;
    localparam logic [2:0]  LNH_RST_IRQ_MASK  = 3'h0;

    // ****************************************************************
    // header field shapes
    // ****************************************************************
    localparam logic [3:0]  LNH_BREAK_BITS    = 4'hE;   // 13 dominant + 1 recessive
    localparam logic [3:0]  LNH_CHAR_BITS     = 4'hA;   // start + 8 data + stop
    localparam logic [7:0]  LNH_SYNC_CHAR     = 8'h55;
    localparam logic [3:0]  LNH_OSR16_LAST    = 4'hF;
    localparam logic [3:0]  LNH_OSR8_LAST     = 4'h7;

    typedef enum logic [1:0] {LNH_IDLE, LNH_BREAK, LNH_SYNC, LNH_IDENT} lnh_state_t;

endpackage : lnh_pkg

// file: tb/lnh_bus_node.sv
/*
 * lnh_bus_node: bus-side sync measurement source feeding the slave role.
 * Assumes the bench raises fire for one clock with the measured divisor on baud.
 */
`timescale 1ns/100ps
module lnh_bus_node (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        fire,
    input  wire logic [15:0] baud,
    output logic             sync_done,
    output logic      [15:0] sync_baud
);
    // outside the pulse the divisor toggles, so a capture taken at the wrong time shows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_done <= 1'b0;
            sync_baud <= 16'hFFFF;
        end else begin
            sync_done <= fire;
            sync_baud <= fire ? baud : ~sync_baud;
        end
    end
endmodule : lnh_bus_node

// file: tb/testbench.sv
/*
 * testbench: role, baud copy, master header and interrupt checks of lnh_lin_node.
 * Assumes zero-wait APB answers and lnh_bus_node as the sync source.
 */
`timescale 1ns/100ps
module testbench;
    import lnh_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, fire, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, sync_done, lin_tx, irq;
    logic [15:0] sync_baud, baud;
    int          bad_count = 0;
    int          compares = 0;
    int          cyc = 0;
    lnh_lin_node u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sync_done(sync_done), .sync_baud(sync_baud), .lin_tx(lin_tx), .irq(irq));
    lnh_bus_node u_node (.pclk(pclk), .presetn(presetn), .fire(fire), .baud(baud),
        .sync_done(sync_done), .sync_baud(sync_baud));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // samples right after the edge, so pready and prdata are the pre-edge values
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_reset();
        apb(0, LNH_OFF_MODE, 32'h0);
        chk("mode", 32'h0, rd);
        apb(0, LNH_OFF_STATUS, 32'h0);
        chk("status", 32'h1, rd);
        apb(0, 8'h18, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        $display("test reset done");
    endtask : test_reset
    task automatic header(input int t, input logic [31:0] mode, input logic [7:0] id, input logic [7:0] ch);
        logic [33:0] exp;
        exp = {1'b1, ch, 1'b0, 1'b1, LNH_SYNC_CHAR, 1'b0, 1'b1, 13'h0};
        apb(1, LNH_OFF_MODE, mode);
        apb(1, LNH_OFF_CTRL, 32'h0000_0003);
        apb(1, LNH_OFF_BAUD_DIV, 32'h0000_0001);
        apb(1, LNH_OFF_IDENT, {24'h0, id});
        apb(0, LNH_OFF_STATUS, 32'h0);
        chk("status busy", 32'h8, rd);
        repeat (t / 2 - 2) @(posedge pclk);
        for (int i = 0; i < 34; i++) begin
            chk("line bit", 32'(exp[i]), 32'(lin_tx));
            repeat (t) @(posedge pclk);
        end
        apb(0, LNH_OFF_STATUS, 32'h0);
        chk("status done", 32'h7, rd);
        chk("irq on", 32'h1, 32'(irq));
        apb(0, LNH_OFF_IRQ_ST, 32'h0);
        chk("irq st", 32'h3, rd);
        apb(1, LNH_OFF_CTRL, 32'h0000_0100);
        apb(0, LNH_OFF_STATUS, 32'h0);
        chk("status clr", 32'h1, rd);
        chk("irq off", 32'h0, 32'(irq));
        $display("test header done");
    endtask : header
    task automatic test_slave();
        apb(1, LNH_OFF_MODE, {28'h0, LNH_ROLE_SLAVE});
        apb(1, LNH_OFF_CTRL, 32'h0000_0003);
        apb(1, LNH_OFF_BAUD_DIV, 32'h0000_1234);
        apb(0, LNH_OFF_BAUD_CAP, 32'h0);
        chk("cap copy", 32'h1234, rd);
        apb(1, LNH_OFF_IDENT, 32'h0000_0011);
        repeat (4) @(posedge pclk);
        chk("slave idle", 32'h1, 32'(lin_tx));
        baud <= 16'h0042;
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(0, LNH_OFF_BAUD_CAP, 32'h0);
        chk("cap sync", 32'h42, rd);
        chk("irq masked", 32'h0, 32'(irq));
        apb(0, LNH_OFF_IRQ_ST, 32'h0);
        chk("sync st", 32'h4, rd);
        $display("test slave done");
    endtask : test_slave
    initial begin
        {psel, penable, pwrite, fire} = 4'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        baud = 16'h0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_reset();
        apb(1, LNH_OFF_IRQ_MASK, 32'h0000_0003);
        header(8, 32'h0000_003A, 8'h05, 8'h85);
        header(16, 32'h0000_000A, 8'hC3, 8'hC3);
        test_slave();
        report_and_stop();
    end
endmodule : testbench
